// *** rtl/output_mixer_control_regs.sv ***
// output mixer control register bank with its two-wire serial control slave
// assumes scl and sda arrive synchronous to clk_i and sda is open drain outside
`timescale 1ns/1ps
`default_nettype none
`include "mixer_regs_cfg.svh"
module output_mixer_control_regs
    import mixer_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h1A // arbitrary value
) (
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    output logic        sda_o,
    output logic        sda_oe_o,
    output mix_route_t  left_output_mixer_route_o,
    output mix_route_t  right_output_mixer_route_o,
    output mix_route_t  speaker_mixer_route_o,
    output mix_atten_t  left_mixer_atten_o,
    output mix_atten_t  right_mixer_atten_o,
    output logic        left_mixer_silence_o,
    output logic        right_mixer_silence_o,
    output speaker_ctl_t speaker_ctl_o
);
    localparam int NREG      = 6;
    localparam int IDX_LROUT = 0;
    localparam int IDX_RROUT = 1;
    localparam int IDX_LATT  = 2;
    localparam int IDX_RATT  = 3;
    localparam int IDX_SROUT = 4;
    localparam int IDX_SGAIN = 5;

    localparam logic [7:0] ADDR_TBL [NREG] = '{
        `ADDR_LEFT_ROUTE,
        `ADDR_RIGHT_ROUTE,
        `ADDR_LEFT_ATTEN,
        `ADDR_RIGHT_ATTEN,
        `ADDR_SPK_ROUTE,
        `ADDR_SPK_GAIN
    };
    localparam logic [8:0] RST_TBL [NREG] = '{
        `RST_ROUTE,
        `RST_ROUTE,
        `RST_ATTEN,
        `RST_ATTEN,
        `RST_ROUTE,
        `RST_SPK_GAIN
    };
    localparam logic [8:0] MASK_TBL [NREG] = '{
        `MASK_ROUTE,
        `MASK_ROUTE,
        `MASK_ATTEN,
        `MASK_ATTEN,
        `MASK_ROUTE,
        `MASK_SPK_GAIN
    };

    if (DEV_ADDR == 7'h00) begin : g_bad_addr
        $error("device address 0 is the general call and cannot be served");
    end

    ser_state_t  s_q;
    ser_state_t  s_d;
    logic [8:0]  reg_val [NREG];
    logic [15:0] rd_val;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;

    // register file, one instance per implemented address
    for (genvar g = 0; g < NREG; g++) begin : g_regs
        ctl_field_reg #(
            .WIDTH (9),
            .RESET (RST_TBL[g]),
            .MASK  (MASK_TBL[g])
        ) u_reg (
            .clk_i     (clk_i),
            .rst_b_i   (rst_b_i),
            .wr_en_i   (s_q.wr_pulse && (s_q.wr_addr == ADDR_TBL[g])),
            .wr_data_i (s_q.wr_data[8:0]),
            .value_o   (reg_val[g])
        );
    end

    // read decode; unmapped addresses and bits 15:9 read zero
    always_comb begin
        rd_val = 16'h0000;
        if (s_q.reg_addr == `ADDR_LEFT_ROUTE) begin
            rd_val = {7'h00, reg_val[IDX_LROUT]};
        end else if (s_q.reg_addr == `ADDR_RIGHT_ROUTE) begin
            rd_val = {7'h00, reg_val[IDX_RROUT]};
        end else if (s_q.reg_addr == `ADDR_LEFT_ATTEN) begin
            rd_val = {7'h00, reg_val[IDX_LATT]};
        end else if (s_q.reg_addr == `ADDR_RIGHT_ATTEN) begin
            rd_val = {7'h00, reg_val[IDX_RATT]};
        end else if (s_q.reg_addr == `ADDR_SPK_ROUTE) begin
            rd_val = {7'h00, reg_val[IDX_SROUT]};
        end else if (s_q.reg_addr == `ADDR_SPK_GAIN) begin
            rd_val = {7'h00, reg_val[IDX_SGAIN]};
        end
    end

    assign scl_rise  = !s_q.scl_prev && scl_i;
    assign scl_fall  = s_q.scl_prev && !scl_i;
    // our own drive only changes while scl is low, so it never forms a false start
    assign bus_start = s_q.scl_prev && scl_i && s_q.sda_prev && !sda_i;
    assign bus_stop  = s_q.scl_prev && scl_i && !s_q.sda_prev && sda_i;

    // serial slave states
    // st_idle    bus free, waiting for a start
    // st_dev     shifting in the device address and direction
    // st_reg     shifting in the register address
    // st_whi     shifting in the upper data byte
    // st_wlo     shifting in the lower data byte, written after its last bit
    // st_ack     pulling sda low for one scl period
    // st_rd      sending read data, one bit per scl period
    // st_rd_ack  sampling the host's acknowledge of a read byte
    // st_ignore  someone else's transfer or surplus bytes, until stop or start
    // start and stop win in every state, so a cut frame never leaves the slave stuck

    always_comb begin
        s_d          = s_q;
        s_d.wr_pulse = 1'b0;
        s_d.scl_prev = scl_i;
        s_d.sda_prev = sda_i;
        if (bus_start) begin
            s_d.st     = ST_DEV;
            s_d.cnt    = 3'h0;
            s_d.full   = 1'b0;
            s_d.sda_oe = 1'b0;
            s_d.second   = 1'b0;
            s_d.host_ack = 1'b0;
            s_d.after    = ST_IDLE;
        end else if (bus_stop) begin
            s_d.st     = ST_IDLE;
            s_d.full   = 1'b0;
            s_d.sda_oe = 1'b0;
            s_d.cnt    = 3'h0;
            s_d.second = 1'b0;
        end else begin
            case (s_q.st)
                ST_DEV, ST_REG, ST_WHI, ST_WLO: begin
                    if (scl_rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda_i};
                        s_d.cnt   = 3'(s_q.cnt + 3'h1);
                        if (s_q.cnt == 3'h7) begin
                            s_d.full = 1'b1;
                        end
                    end else if (scl_fall && s_q.full) begin
                        s_d.full   = 1'b0;
                        s_d.cnt    = 3'h0;
                        s_d.st     = ST_ACK;
                        s_d.sda_oe = 1'b1;
                        if (s_q.st == ST_DEV) begin
                            if (s_q.shreg[7:1] == DEV_ADDR) begin
                                s_d.rw    = s_q.shreg[0];
                                s_d.after = s_q.shreg[0] ? ST_RD : ST_REG;
                            end else begin
                                s_d.st     = ST_IGNORE;
                                s_d.sda_oe = 1'b0;
                            end
                        end else if (s_q.st == ST_REG) begin
                            s_d.reg_addr = s_q.shreg;
                            s_d.after    = ST_WHI;
                        end else if (s_q.st == ST_WHI) begin
                            s_d.wr_hi = s_q.shreg;
                            s_d.after = ST_WLO;
                        end else begin
                            // one word per transfer; later bytes go unacknowledged
                            s_d.wr_pulse = 1'b1;
                            s_d.wr_addr  = s_q.reg_addr;
                            s_d.wr_data  = {s_q.wr_hi, s_q.shreg};
                            s_d.after    = ST_IGNORE;
                        end
                    end
                end

                ST_ACK: begin
                    if (scl_fall) begin
                        s_d.st     = s_q.after;
                        s_d.cnt    = 3'h0;
                        s_d.sda_oe = 1'b0;
                        if (s_q.rw && (s_q.after == ST_RD)) begin
                            s_d.rd_word = rd_val;
                            s_d.second  = 1'b0;
                            s_d.sda_oe  = ~rd_val[15];
                        end
                    end
                end

                ST_RD: begin
                    if (scl_fall) begin
                        s_d.rd_word = {s_q.rd_word[14:0], 1'b0};
                        if (s_q.cnt == 3'h7) begin
                            s_d.sda_oe = 1'b0;
                            s_d.cnt    = 3'h0;
                            s_d.st     = ST_RD_ACK;
                        end else begin
                            s_d.cnt    = 3'(s_q.cnt + 3'h1);
                            s_d.sda_oe = ~s_q.rd_word[14];
                        end
                    end
                end

                ST_RD_ACK: begin
                    if (scl_rise) begin
                        s_d.host_ack = ~sda_i;
                    end else if (scl_fall) begin
                        if (s_q.host_ack && !s_q.second) begin
                            s_d.second = 1'b1;
                            s_d.st     = ST_RD;
                            s_d.sda_oe = ~s_q.rd_word[15];
                        end else begin
                            s_d.st = ST_IGNORE;
                        end
                    end
                end

                ST_IDLE, ST_IGNORE: begin
                    s_d.sda_oe = 1'b0;
                    s_d.full   = 1'b0;
                    s_d.cnt    = 3'h0;
                end

                default: begin
                    s_d.st     = ST_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
        // the stored level only reaches the amplifier on a write that carries the apply bit
        if (s_q.wr_pulse && (s_q.wr_addr == `ADDR_SPK_GAIN) && s_q.wr_data[`BIT_SPK_APPLY]) begin
            s_d.gain_applied = s_q.wr_data[5:0];
        end
        s_d.gain_db = 7'({1'b0, s_d.gain_applied} - `SPK_GAIN_FLOOR_DB);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q.st           <= ST_IDLE;
            s_q.after        <= ST_IDLE;
            s_q.shreg        <= 8'h00;
            s_q.cnt          <= 3'h0;
            s_q.full         <= 1'b0;
            s_q.rw           <= 1'b0;
            s_q.second       <= 1'b0;
            s_q.host_ack     <= 1'b0;
            s_q.reg_addr     <= 8'h00;
            s_q.wr_hi        <= 8'h00;
            s_q.rd_word      <= 16'h0000;
            s_q.sda_oe       <= 1'b0;
            s_q.sda_out      <= 1'b0;
            s_q.scl_prev     <= 1'b1;
            s_q.sda_prev     <= 1'b1;
            s_q.wr_pulse     <= 1'b0;
            s_q.wr_addr      <= 8'h00;
            s_q.wr_data      <= 16'h0000;
            s_q.gain_applied <= `RST_SPK_LEVEL;
            s_q.gain_db      <= `RST_SPK_DB;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: the pin value is always low, only the enable moves
    assign sda_o    = s_q.sda_out;
    assign sda_oe_o = s_q.sda_oe;

    assign left_output_mixer_route_o.first_input_a  = reg_val[IDX_LROUT][`BIT_FIRST_A];
    assign left_output_mixer_route_o.first_input_b  = reg_val[IDX_LROUT][`BIT_FIRST_B];
    assign left_output_mixer_route_o.second_input_a = reg_val[IDX_LROUT][`BIT_SECOND_A];
    assign left_output_mixer_route_o.second_input_b = reg_val[IDX_LROUT][`BIT_SECOND_B];

    assign right_output_mixer_route_o.first_input_a  = reg_val[IDX_RROUT][`BIT_FIRST_A];
    assign right_output_mixer_route_o.first_input_b  = reg_val[IDX_RROUT][`BIT_FIRST_B];
    assign right_output_mixer_route_o.second_input_a = reg_val[IDX_RROUT][`BIT_SECOND_A];
    assign right_output_mixer_route_o.second_input_b = reg_val[IDX_RROUT][`BIT_SECOND_B];

    assign speaker_mixer_route_o.first_input_a  = reg_val[IDX_SROUT][`BIT_FIRST_A];
    assign speaker_mixer_route_o.first_input_b  = reg_val[IDX_SROUT][`BIT_FIRST_B];
    assign speaker_mixer_route_o.second_input_a = reg_val[IDX_SROUT][`BIT_SECOND_A];
    assign speaker_mixer_route_o.second_input_b = reg_val[IDX_SROUT][`BIT_SECOND_B];

    assign left_mixer_silence_o  = reg_val[IDX_LATT][`BIT_SILENCE];
    assign right_mixer_silence_o = reg_val[IDX_RATT][`BIT_SILENCE];

    assign left_mixer_atten_o.first_input_a  =
        atten_t'(reg_val[IDX_LATT][`LSB_ATT_FIRST_A +: 2]);
    assign left_mixer_atten_o.first_input_b  =
        atten_t'(reg_val[IDX_LATT][`LSB_ATT_FIRST_B +: 2]);
    assign left_mixer_atten_o.second_input_a =
        atten_t'(reg_val[IDX_LATT][`LSB_ATT_SECOND_A +: 2]);
    assign left_mixer_atten_o.second_input_b =
        atten_t'(reg_val[IDX_LATT][`LSB_ATT_SECOND_B +: 2]);

    assign right_mixer_atten_o.first_input_a  =
        atten_t'(reg_val[IDX_RATT][`LSB_ATT_FIRST_A +: 2]);
    assign right_mixer_atten_o.first_input_b  =
        atten_t'(reg_val[IDX_RATT][`LSB_ATT_FIRST_B +: 2]);
    assign right_mixer_atten_o.second_input_a =
        atten_t'(reg_val[IDX_RATT][`LSB_ATT_SECOND_A +: 2]);
    assign right_mixer_atten_o.second_input_b =
        atten_t'(reg_val[IDX_RATT][`LSB_ATT_SECOND_B +: 2]);

    assign speaker_ctl_o.zero_cross         = reg_val[IDX_SGAIN][`BIT_SPK_ZERO_CROSS];
    assign speaker_ctl_o.silence            = reg_val[IDX_SGAIN][`BIT_SPK_SILENCE];
    assign speaker_ctl_o.speaker_gain_level = s_q.gain_applied;
    assign speaker_ctl_o.gain_db            = s_q.gain_db;

endmodule : output_mixer_control_regs
`default_nettype wire

// *** rtl/mixer_regs_cfg.svh ***
// constants for the output mixer control register bank: offsets, field positions, resets
// assumes the two-wire control port carries an 8-bit register address and a 16-bit word
`ifndef MIXER_REGS_CFG_SVH
`define MIXER_REGS_CFG_SVH

`define ADDR_LEFT_ROUTE     8'h2D
`define ADDR_RIGHT_ROUTE    8'h2E
`define ADDR_LEFT_ATTEN     8'h2F
`define ADDR_RIGHT_ATTEN    8'h30
`define ADDR_SPK_ROUTE      8'h36
`define ADDR_SPK_GAIN       8'h26

`define MASK_ROUTE          9'h055
`define MASK_ATTEN          9'h1FF
`define MASK_SPK_GAIN       9'h0FF

`define RST_ROUTE           9'h000
`define RST_ATTEN           9'h100
`define RST_SPK_GAIN        9'h039
`define RST_SPK_LEVEL       6'h39
`define RST_SPK_DB          7'h00

`define BIT_FIRST_A         6
`define BIT_FIRST_B         4
`define BIT_SECOND_A        2
`define BIT_SECOND_B        0
`define BIT_SILENCE         8
`define LSB_ATT_FIRST_A     6
`define LSB_ATT_FIRST_B     4
`define LSB_ATT_SECOND_A    2
`define LSB_ATT_SECOND_B    0
`define BIT_SPK_APPLY       8
`define BIT_SPK_ZERO_CROSS  7
`define BIT_SPK_SILENCE     6
`define SPK_GAIN_FLOOR_DB   7'd57

`endif

// *** rtl/mixer_regs_pkg.sv ***
// types shared by the output mixer control register bank
// assumes nothing beyond a SystemVerilog-2012 compiler
`default_nettype none
package mixer_regs_pkg;

    typedef enum logic [1:0] {
        ATT_0DB   = 2'h0,
        ATT_M6DB  = 2'h1,
        ATT_M9DB  = 2'h2,
        ATT_M12DB = 2'h3
    } atten_t;

    typedef struct packed {
        logic first_input_a;
        logic first_input_b;
        logic second_input_a;
        logic second_input_b;
    } mix_route_t;

    typedef struct packed {
        atten_t first_input_a;
        atten_t first_input_b;
        atten_t second_input_a;
        atten_t second_input_b;
    } mix_atten_t;

    typedef struct packed {
        logic        zero_cross;
        logic        silence;
        logic [5:0]  speaker_gain_level;
        logic [6:0]  gain_db;
    } speaker_ctl_t;

    typedef enum logic [9:0] {
        ST_IDLE   = 10'h001,
        ST_DEV    = 10'h002,
        ST_REG    = 10'h004,
        ST_WHI    = 10'h008,
        ST_WLO    = 10'h010,
        ST_ACK    = 10'h020,
        ST_RD     = 10'h040,
        ST_RD_ACK = 10'h080,
        ST_IGNORE = 10'h100,
        ST_SPARE  = 10'h200
    } ser_st_t;

    typedef struct packed {
        ser_st_t     st;
        ser_st_t     after;
        logic [7:0]  shreg;
        logic [2:0]  cnt;
        logic        full;
        logic        rw;
        logic        second;
        logic        host_ack;
        logic [7:0]  reg_addr;
        logic [7:0]  wr_hi;
        logic [15:0] rd_word;
        logic        sda_oe;
        logic        sda_out;
        logic        scl_prev;
        logic        sda_prev;
        logic        wr_pulse;
        logic [7:0]  wr_addr;
        logic [15:0] wr_data;
        logic [5:0]  gain_applied;
        logic [6:0]  gain_db;
    } ser_state_t;

endpackage : mixer_regs_pkg
`default_nettype wire

// *** rtl/ctl_field_reg.sv ***
// one control register with a reset value and a mask of implemented bits
// assumes a write enable pulse of one cycle and data aligned to bit 0
`timescale 1ns/1ps
`default_nettype none
module ctl_field_reg #(
    parameter int              WIDTH = 9,
    parameter logic [WIDTH-1:0] RESET = '0,
    parameter logic [WIDTH-1:0] MASK  = '1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             wr_en_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    output logic      [WIDTH-1:0] value_o
);
    typedef struct packed {
        logic [WIDTH-1:0] value;
    } field_state_t;

    field_state_t f_q;
    field_state_t f_d;

    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("ctl_field_reg width must be 1 to 16");
    end

    always_comb begin
        f_d = f_q;
        if (wr_en_i) begin
            f_d.value = wr_data_i & MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            f_q.value <= RESET & MASK;
        end else begin
            f_q <= f_d;
        end
    end

    assign value_o = f_q.value;

endmodule : ctl_field_reg
`default_nettype wire

// *** verif/output_mixer_control_regs_chk.sv ***
// checker for the output mixer control register bank, watching its top ports
// assumes synchronous active-low reset and scl sampled on every rising clk edge
`timescale 1ns/1ps
`default_nettype none
module output_mixer_control_regs_chk
    import mixer_regs_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         rst_b_i,
    input wire logic         scl_i,
    input wire logic         sda_i,
    input wire logic         sda_o,
    input wire logic         sda_oe_o,
    input wire mix_route_t   left_output_mixer_route_o,
    input wire mix_route_t   right_output_mixer_route_o,
    input wire mix_route_t   speaker_mixer_route_o,
    input wire mix_atten_t   left_mixer_atten_o,
    input wire mix_atten_t   right_mixer_atten_o,
    input wire logic         left_mixer_silence_o,
    input wire logic         right_mixer_silence_o,
    input wire speaker_ctl_t speaker_ctl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_ROUTE_RESET: assert property ($rose(rst_b_i) |-> left_output_mixer_route_o == 4'h0
        && right_output_mixer_route_o == 4'h0 && speaker_mixer_route_o == 4'h0)
        else $error("routing not cleared by reset");
    AST_SILENCE_RESET: assert property ($rose(rst_b_i) |-> left_mixer_silence_o && right_mixer_silence_o)
        else $error("mixers not muted after reset");
    AST_ATTEN_RESET: assert property ($rose(rst_b_i) |-> {left_mixer_atten_o, right_mixer_atten_o} == 16'h0000)
        else $error("attenuation not zero after reset");
    AST_GAIN_RESET: assert property ($rose(rst_b_i) |-> speaker_ctl_o.speaker_gain_level == 6'h39)
        else $error("speaker level not at default after reset");
    AST_GAIN_DB_MAP: assert property (speaker_ctl_o.gain_db == {1'b0, speaker_ctl_o.speaker_gain_level} - 7'd57)
        else $error("speaker gain in dB does not follow the level code");
    // a register only moves two clocks after the scl fall that ends its last data byte
    AST_ROUTE_UPDATE: assert property ($changed({left_output_mixer_route_o, right_output_mixer_route_o,
        speaker_mixer_route_o}) |-> !$past(scl_i, 2) && $past(scl_i, 3))
        else $error("routing changed away from a byte end");
    AST_ATTEN_UPDATE: assert property ($changed({left_mixer_atten_o, right_mixer_atten_o,
        left_mixer_silence_o, right_mixer_silence_o}) |-> !$past(scl_i, 2) && $past(scl_i, 3))
        else $error("attenuation changed away from a byte end");
    AST_GAIN_UPDATE: assert property ($changed(speaker_ctl_o.speaker_gain_level)
        |-> !$past(scl_i, 2) && $past(scl_i, 3))
        else $error("speaker level changed away from a byte end");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
        else $error("sda drive changed while scl high");
    AST_SDA_DRIVE_LOW: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("sda driven high");

    cover property ($rose(sda_oe_o));
    cover property ($fell(left_mixer_silence_o));
    cover property ($changed(speaker_ctl_o.speaker_gain_level));
endmodule : output_mixer_control_regs_chk

bind output_mixer_control_regs output_mixer_control_regs_chk output_mixer_control_regs_chk_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .left_output_mixer_route_o(left_output_mixer_route_o),
    .right_output_mixer_route_o(right_output_mixer_route_o),
    .speaker_mixer_route_o(speaker_mixer_route_o), .left_mixer_atten_o(left_mixer_atten_o),
    .right_mixer_atten_o(right_mixer_atten_o), .left_mixer_silence_o(left_mixer_silence_o),
    .right_mixer_silence_o(right_mixer_silence_o), .speaker_ctl_o(speaker_ctl_o));
`default_nettype wire

// *** verif/host_two_wire_model.sv ***
// two-wire host model: word writes and reads issued by the bench
// assumes sda_i is the resolved wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module host_two_wire_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // sda moves a clock after scl so no false start or stop is seen
    task automatic half(input logic c, input logic d);
        @(negedge clk_i);
        scl_o = c;
        @(negedge clk_i);
        sda_o = d;
        @(negedge clk_i);
    endtask : half
    task automatic start();
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
        half(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        half(1'b0, 1'b0);
        half(1'b1, 1'b0);
        half(1'b1, 1'b1);
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            half(1'b0, b[i]);
            half(1'b1, b[i]);
        end
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
        ack = ~sda_i;
    endtask : send_byte
    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            half(1'b0, 1'b1);
            half(1'b1, 1'b1);
            b[i] = sda_i;
        end
        half(1'b0, last);
        half(1'b1, last);
    endtask : recv_byte
    task automatic write_word(input logic [6:0] dev, input logic [7:0] a,
                              input logic [15:0] d, output logic [3:0] k);
        start();
        send_byte({dev, 1'b0}, k[3]);
        send_byte(a, k[2]);
        send_byte(d[15:8], k[1]);
        send_byte(d[7:0], k[0]);
        stop();
    endtask : write_word
    task automatic read_word(input logic [6:0] dev, input logic [7:0] a,
                             output logic [15:0] d, output logic [2:0] k);
        start();
        send_byte({dev, 1'b0}, k[2]);
        send_byte(a, k[1]);
        start();
        send_byte({dev, 1'b1}, k[0]);
        recv_byte(1'b0, d[15:8]);
        recv_byte(1'b1, d[7:0]);
        stop();
    endtask : read_word
endmodule : host_two_wire_model
`default_nettype wire

// *** verif/output_mixer_control_regs_test.sv ***
// self-checking bench for the output mixer register bank through the host model
// assumes the host model owns scl and sda is resolved here with a pull-up
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module output_mixer_control_regs_test;
    import mixer_regs_pkg::*;
    localparam logic [6:0] DEV = 7'h1A; // arbitrary value
    localparam logic [7:0] ADR [6] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h36, 8'h26};
    localparam logic [15:0] RSTV [6] = '{16'h0, 16'h0, 16'h100, 16'h100, 16'h0, 16'h39};
    localparam logic [15:0] ONES [5] = '{16'h55, 16'h55, 16'h1FF, 16'h1FF, 16'h55};
    logic         clk_i, rst_b_i, scl, sda_host, sda_o, sda_oe_o, ls, rs;
    wire          sda;
    mix_route_t   lr, rr, sr;
    mix_atten_t   la, ra;
    speaker_ctl_t spk;
    logic [7:0]   att;
    int           fail_count, tests_run;
    // open drain: anyone enabled pulls low, else the pull-up wins
    assign sda = sda_host & ~sda_oe_o;
    host_two_wire_model host_two_wire_model_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_o(sda_host));
    output_mixer_control_regs #(.DEV_ADDR(DEV)) output_mixer_control_regs_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .left_output_mixer_route_o(lr), .right_output_mixer_route_o(rr),
        .speaker_mixer_route_o(sr), .left_mixer_atten_o(la), .right_mixer_atten_o(ra),
        .left_mixer_silence_o(ls), .right_mixer_silence_o(rs), .speaker_ctl_o(spk));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [3:0] k;
        host_two_wire_model_inst.write_word(DEV, a, d, k);
        `CHECK("write acks", 4'hF, k)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic [2:0]  k;
        host_two_wire_model_inst.read_word(DEV, a, d, k);
        `CHECK("read acks", 3'h7, k)
        `CHECK("read data", e, d)
    endtask : rd
    task automatic reset_check();
        `CHECK("routes", 12'h000, {lr, rr, sr})
        `CHECK("atten", 16'h0000, {la, ra})
        `CHECK("silence", 2'b11, {ls, rs})
        `CHECK("speaker", 15'h1C80, spk)
        for (int i = 0; i < 6; i++) rd(ADR[i], RSTV[i]);
    endtask : reset_check
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    initial begin
        logic [3:0] k;
        rst_b_i = 1'b0;
        fail_count = 0;
        tests_run = 0;
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        reset_check();
        // reserved bits ignore writes, every implemented bit of the routing and attenuation registers turns on
        for (int i = 0; i < 5; i++) wr(ADR[i], 16'hFFFF);
        for (int i = 0; i < 5; i++) rd(ADR[i], ONES[i]);
        `CHECK("routes on", 12'hFFF, {lr, rr, sr})
        `CHECK("silence on", 2'b11, {ls, rs})
        // one input at a time on each routing register
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 4; i++) begin
                wr(ADR[r == 2 ? 4 : r], 16'h0001 << (2 * i));
                `CHECK("route bit", 4'h1 << i, r == 0 ? lr : r == 1 ? rr : sr)
            end
        end
        for (int c = 0; c < 4; c++) begin
            att = {4{c[1:0]}};
            wr(8'h2F, {7'h7F, 1'b0, att});
            `CHECK("left atten", att, la)
            `CHECK("left silence", 1'b0, ls)
            rd(8'h2F, {8'h00, att});
        end
        wr(8'h30, 16'h001B);
        `CHECK("right atten", 8'h1B, ra)
        `CHECK("right silence", 1'b0, rs)
        wr(8'h30, 16'h0100);
        `CHECK("right mute", 9'h100, {rs, ra})
        `CHECK("left kept", 8'hFF, la)
        // volume stored without the apply bit must not reach the output
        wr(8'h26, 16'h00C5);
        `CHECK("level held", 6'h39, spk.speaker_gain_level)
        `CHECK("zc mute", 2'b11, {spk.zero_cross, spk.silence})
        rd(8'h26, 16'h00C5);
        wr(8'h26, 16'h0100);
        `CHECK("level min", 13'h0047, {spk.speaker_gain_level, spk.gain_db})
        wr(8'h26, 16'h013F);
        `CHECK("level max", 13'h1F86, {spk.speaker_gain_level, spk.gain_db})
        // a foreign device address is ignored for the whole transfer
        host_two_wire_model_inst.write_word(DEV ^ 7'h01, 8'h2F, 16'h0000, k);
        `CHECK("foreign acks", 4'h0, k)
        `CHECK("foreign kept", 9'h0FF, {ls, la})
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 16'h0000);
        @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        reset_check();
        close_out();
    end
endmodule : output_mixer_control_regs_test
`default_nettype wire
